// [sim/converter_config_regs_test.sv]
// Self-checking bench for the converter configuration register bank.
// Assumes host_model drives the register port; one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("MISMATCH %0t %s", $time, msg); \
        end \
    end
module converter_config_regs_test;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic rvalid;
    conv_cfg_pkg::conv_cfg_s cfg;
    logic [7:0] shadow [4];
    logic [7:0] mask [4] = '{8'h7f, 8'hff, 8'h7f, 8'hff};
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    converter_config_regs i_converter_config_regs (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata),
        .rvalid_o(rvalid), .cfg_o(cfg));
    host_model i_host_model (
        .clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

    // ------------------------------------------------------------
    // Expected decode and shared checks
    // ------------------------------------------------------------
    // code three folds onto 75 mA
    function automatic conv_cfg_pkg::conv_cfg_s exp_cfg();
        logic [1:0] dc;
        dc = (shadow[2][3:2] == 2'h3) ? 2'h2 : shadow[2][3:2];
        return {shadow[0][6:0], shadow[1], shadow[2][6:4], dc,
                shadow[2][1:0], shadow[3]};
    endfunction

    task automatic check_all();
        logic [7:0] d;
        logic [7:0] x;
        logic v1;
        logic v0;
        conv_cfg_pkg::conv_cfg_s e;
        for (int i = 0; i < 6; i++) begin
            i_host_model.read_reg(8'hcf + 8'(i), d, v1, v0);
            x = (i == 0 || i == 5) ? 8'h00 : shadow[i - 1];
            `CHK(d, x, "readback")
            `CHK(v1, 1'b1, "valid missing")
            `CHK(v0, 1'b0, "valid too long")
        end
        e = exp_cfg();
        `CHK(cfg[29:23], e[29:23], "cfg0")
        `CHK(cfg[22:15], e[22:15], "cfg1")
        `CHK(cfg[14:8], e[14:8], "cfg2")
        `CHK(cfg[7:0], e[7:0], "cfg3")
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // reset values reload
    task automatic t_reset();
        rst_n_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        shadow = '{8'h32, 8'h09, 8'h40, 8'h20};
        `CHK(rdata, 8'h00, "rdata after reset")
        `CHK(rvalid, 1'b0, "rvalid after reset")
        check_all();
    endtask

    // Walking ones, all ones, all zeros: every code of every one- and two-bit field
    task automatic t_walk();
        logic [7:0] v;
        for (int r = 0; r < 4; r++) begin
            for (int b = 0; b < 10; b++) begin
                v = (b < 8) ? (8'h01 << b) : ((b == 8) ? 8'hff : 8'h00);
                i_host_model.write_reg(8'hd0 + 8'(r), v);
                shadow[r] = v & mask[r];
                check_all();
            end
        end
    endtask

    // Writes outside the bank leave every register alone
    task automatic t_unmapped();
        i_host_model.write_reg(8'hd2, 8'h2c);
        shadow[2] = 8'h2c;
        i_host_model.write_reg(8'hd4, 8'hff);
        i_host_model.write_reg(8'hcf, 8'h00);
        check_all();
    endtask

    // Back-to-back writes, then a reset in mid-run
    task automatic t_burst_reset();
        i_host_model.write_pair(8'hd1, 8'ha5, 8'hd3, 8'h5a);
        shadow[1] = 8'ha5;
        shadow[3] = 8'h5a;
        check_all();
        i_host_model.write_reg(8'hd0, 8'h01);
        shadow[0] = 8'h01;
        `CHK(cfg.power_stage_enable, 1'b1, "stage enable")
        t_reset();
    endtask

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run takes about 600 cycles; the ceiling leaves margin
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("MISMATCH %0t run limit reached", $time);
            close_out();
        end
    end

    initial begin
        t_reset();
        t_walk();
        t_unmapped();
        t_burst_reset();
        close_out();
    end
endmodule // converter_config_regs_test

// [sim/host_model.sv]
// Host model: the serial interface logic that drives the register port.
// Assumes the bench calls its tasks 1 ns after a rising clock edge.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end

    // Idle data is inverted so a stale byte never passes for a fresh one
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    // Two writes on consecutive edges, strobe held high between them
    task automatic write_pair(input logic [7:0] a0, input logic [7:0] d0,
                              input logic [7:0] a1, input logic [7:0] d1);
        addr_o = a0;
        wdata_o = d0;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        addr_o = a1;
        wdata_o = d1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d1;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic v1, output logic v0);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        rd_o = 1'b0;
        d = rdata_i;
        v1 = rvalid_i;
        @(posedge clk_sys_i);
        #1;
        v0 = rvalid_i;
    endtask
endmodule // host_model

// [verilog/cfg_byte_reg.sv]
// One 8-bit configuration register with a mask of implemented bits.
// Assumes a one-cycle write strobe on the system clock.
`timescale 1ns/1ps
module cfg_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] q_o
);
    logic [7:0] value_r;

    // Masked bits never store, so they read back as zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            value_r <= RESET_VAL & IMPL_MASK;
        end else if (wr_i) begin
            value_r <= wdata_i & IMPL_MASK;
        end
    end

    assign q_o = value_r;
endmodule // cfg_byte_reg

// [verilog/cfg_readback.sv]
// Read multiplexer for the four configuration registers.
// Assumes register values already masked; unmapped offsets read zero.
`timescale 1ns/1ps
module cfg_readback (
    input wire logic [7:0] addr_i,
    input wire logic [7:0] cfg0_i,
    input wire logic [7:0] cfg1_i,
    input wire logic [7:0] cfg2_i,
    input wire logic [7:0] cfg3_i,
    output logic [7:0] rdata_o
);
    always_comb begin
        case (addr_i)
            conv_cfg_pkg::ADDR_CONFIG0: rdata_o = cfg0_i;
            conv_cfg_pkg::ADDR_CONFIG1: rdata_o = cfg1_i;
            conv_cfg_pkg::ADDR_SLEW_DISCH: rdata_o = cfg2_i;
            conv_cfg_pkg::ADDR_INPUT_DET: rdata_o = cfg3_i;
            default: rdata_o = 8'h00;
        endcase
    end
endmodule // cfg_readback

// [verilog/conv_cfg_pkg.sv]
// Package: offsets, field positions, reset values and field structs
// for the converter configuration register bank.
// Assumes an 8-bit register access port from the serial interface logic.
package conv_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG0 = 8'hd0;
    localparam logic [7:0] ADDR_CONFIG1 = 8'hd1;
    localparam logic [7:0] ADDR_SLEW_DISCH = 8'hd2;
    localparam logic [7:0] ADDR_INPUT_DET = 8'hd3;

    // ------------------------------------------------------------
    // Reset values and implemented-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONFIG0 = 8'h32;
    localparam logic [7:0] RST_CONFIG1 = 8'h09;
    localparam logic [7:0] RST_SLEW_DISCH = 8'h40;
    localparam logic [7:0] RST_INPUT_DET = 8'h20;
    localparam logic [7:0] MASK_CONFIG0 = 8'h7f;
    localparam logic [7:0] MASK_CONFIG1 = 8'hff;
    localparam logic [7:0] MASK_SLEW_DISCH = 8'h7f;
    localparam logic [7:0] MASK_INPUT_DET = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C0_NEG_LIMIT = 6;
    localparam int C0_AUX_REG = 5;
    localparam int C0_IMON_LIM = 4;
    localparam int C0_HICCUP = 3;
    localparam int C0_SPREAD = 2;
    localparam int C0_USLEEP = 1;
    localparam int C0_STAGE = 0;
    localparam int C1_THW_EN = 7;
    localparam int C1_THW_LSB = 5;
    localparam int C1_FAULT_INT = 4;
    localparam int C1_TRK_DIRECT = 3;
    localparam int C1_BIAS_PRIO = 2;
    localparam int C1_2P_FORCED = 1;
    localparam int C1_2P_SAVE = 0;
    localparam int C2_ACT_DOWN = 6;
    localparam int C2_SLEW_LSB = 4;
    localparam int C2_DISCH_LSB = 2;
    localparam int C2_DISCH_STAGE = 1;
    localparam int C2_DISCH_THR = 0;
    localparam int C3_IVP = 7;
    localparam int C3_IVR = 6;
    localparam int C3_DET_EN = 5;
    localparam int C3_DET_LSB = 0;

    // Discharge current codes after folding code three onto fast
    localparam logic [1:0] DISCH_FAST = 2'h2;

    // ------------------------------------------------------------
    // Decoded configuration carried to the analog controls
    // ------------------------------------------------------------
    typedef struct packed {
        logic negative_limit_enable;
        logic aux_regulator_enable;
        logic imon_limiter_enable;
        logic hiccup_enable;
        logic dual_spread_enable;
        logic micro_sleep_enable;
        logic power_stage_enable;
        logic thermal_warning_enable;
        logic [1:0] thermal_warning_level;
        logic fault_pin_interrupt_mode;
        logic tracking_direct_startup;
        logic bias_supply_priority;
        logic two_phase_forced_pwm_enable;
        logic two_phase_power_save_enable;
        logic active_down_ramp_enable;
        logic [1:0] ramp_slew_select;
        logic [1:0] discharge_current_select;
        logic discharge_with_stage_enable;
        logic discharge_to_threshold;
        logic input_protect_enable;
        logic input_regulation_select;
        logic voltage_detect_enable;
        logic [4:0] voltage_detect_falling_level;
    } conv_cfg_s;

endpackage

// [verilog/converter_config_regs.sv]
// Converter configuration register bank: four 8-bit registers at
// offsets d0..d3, written and read by the serial interface logic.
// Assumes wr/rd strobes are one-cycle pulses on clk_sys_i.
//
// Contract
// - Unimplemented bits drop writes and read back zero.
// - Config0 bit 6 also limits negative current; resets clear.
// - Config0 bit 5 enables the auxiliary regulator; resets enabled.
// - Config0 bit 4 enables current monitor limiter; resets one.
// - Config0 bit 3 enables hiccup short protection; resets zero.
// - Config0 bit 2 enables dual spread spectrum; resets zero.
// - Config0 bit 1 enables micro sleep; resets one.
// - Config0 bit 0 enables power stage; resets zero.
// - Config1 bit 7 enables thermal warning; resets zero.
// - Config1 bits 6:5 pick 140/125/110/95 C warning level; reset zero.
// - Config1 bit 4 makes fault pin an interrupt output; resets zero.
// - Config1 bit 3 gives direct start under tracking; resets one.
// - Config1 bit 2 prefers bias input for second supply; resets zero.
// - Bit 1 two-phase in forced PWM (reset 0), bit 0 power save (1).
// - Config2 bit 6 enables active down ramp; resets one.
// - Config2 bits 5:4 pick ramp slew 40/20/1/0.5 mV/us.
// - Config2 bits 3:2 pick 25/50/75 mA; code three is 75 mA.
// - Config2 bit 1 ties discharge to power stage enable; resets zero.
// - Config2 bit 0 discharges until threshold voltage; resets zero.
// - Config3 bit 7 input protection, bit 6 regulation instead; reset zero.
// - Config3 bit 5 voltage detect (reset 1); bits 4:0 falling level.
`timescale 1ns/1ps
module converter_config_regs (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output conv_cfg_pkg::conv_cfg_s cfg_o
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] rd_mux;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic wr0;
    logic wr1;
    logic wr2;
    logic wr3;
    logic [1:0] disch_sel;

    assign wr0 = wr_i && (addr_i == conv_cfg_pkg::ADDR_CONFIG0);
    assign wr1 = wr_i && (addr_i == conv_cfg_pkg::ADDR_CONFIG1);
    assign wr2 = wr_i && (addr_i == conv_cfg_pkg::ADDR_SLEW_DISCH);
    assign wr3 = wr_i && (addr_i == conv_cfg_pkg::ADDR_INPUT_DET);

    cfg_byte_reg #(
        .RESET_VAL(conv_cfg_pkg::RST_CONFIG0),
        .IMPL_MASK(conv_cfg_pkg::MASK_CONFIG0)
    ) u_cfg0 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr0),
        .wdata_i(wdata_i),
        .q_o(cfg0)
    );

    cfg_byte_reg #(
        .RESET_VAL(conv_cfg_pkg::RST_CONFIG1),
        .IMPL_MASK(conv_cfg_pkg::MASK_CONFIG1)
    ) u_cfg1 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr1),
        .wdata_i(wdata_i),
        .q_o(cfg1)
    );

    cfg_byte_reg #(
        .RESET_VAL(conv_cfg_pkg::RST_SLEW_DISCH),
        .IMPL_MASK(conv_cfg_pkg::MASK_SLEW_DISCH)
    ) u_cfg2 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr2),
        .wdata_i(wdata_i),
        .q_o(cfg2)
    );

    cfg_byte_reg #(
        .RESET_VAL(conv_cfg_pkg::RST_INPUT_DET),
        .IMPL_MASK(conv_cfg_pkg::MASK_INPUT_DET)
    ) u_cfg3 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr3),
        .wdata_i(wdata_i),
        .q_o(cfg3)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    cfg_readback u_rb (
        .addr_i(addr_i),
        .cfg0_i(cfg0),
        .cfg1_i(cfg1),
        .cfg2_i(cfg2),
        .cfg3_i(cfg3),
        .rdata_o(rd_mux)
    );

    // Registered read data so the serial shifter sees a stable byte
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= rd_i;
            if (rd_i) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;

    // ------------------------------------------------------------
    // Field decode to converter controls
    // ------------------------------------------------------------
    // negative limit
    assign cfg_o.negative_limit_enable = cfg0[conv_cfg_pkg::C0_NEG_LIMIT];
    assign cfg_o.aux_regulator_enable = cfg0[conv_cfg_pkg::C0_AUX_REG];
    assign cfg_o.imon_limiter_enable = cfg0[conv_cfg_pkg::C0_IMON_LIM];
    assign cfg_o.hiccup_enable = cfg0[conv_cfg_pkg::C0_HICCUP];
    assign cfg_o.dual_spread_enable = cfg0[conv_cfg_pkg::C0_SPREAD];
    assign cfg_o.micro_sleep_enable = cfg0[conv_cfg_pkg::C0_USLEEP];
    assign cfg_o.power_stage_enable = cfg0[conv_cfg_pkg::C0_STAGE];
    assign cfg_o.thermal_warning_enable = cfg1[conv_cfg_pkg::C1_THW_EN];
    assign cfg_o.thermal_warning_level =
        cfg1[conv_cfg_pkg::C1_THW_LSB +: 2];
    assign cfg_o.fault_pin_interrupt_mode =
        cfg1[conv_cfg_pkg::C1_FAULT_INT];
    assign cfg_o.tracking_direct_startup =
        cfg1[conv_cfg_pkg::C1_TRK_DIRECT];
    assign cfg_o.bias_supply_priority = cfg1[conv_cfg_pkg::C1_BIAS_PRIO];
    assign cfg_o.two_phase_forced_pwm_enable =
        cfg1[conv_cfg_pkg::C1_2P_FORCED];
    assign cfg_o.two_phase_power_save_enable =
        cfg1[conv_cfg_pkg::C1_2P_SAVE];
    assign cfg_o.active_down_ramp_enable = cfg2[conv_cfg_pkg::C2_ACT_DOWN];
    assign cfg_o.ramp_slew_select = cfg2[conv_cfg_pkg::C2_SLEW_LSB +: 2];
    // discharge current, code three folded onto fast
    always_comb begin
        disch_sel = cfg2[conv_cfg_pkg::C2_DISCH_LSB +: 2];
        if (disch_sel > conv_cfg_pkg::DISCH_FAST) begin
            disch_sel = conv_cfg_pkg::DISCH_FAST;
        end
    end
    assign cfg_o.discharge_current_select = disch_sel;
    assign cfg_o.discharge_with_stage_enable =
        cfg2[conv_cfg_pkg::C2_DISCH_STAGE];
    assign cfg_o.discharge_to_threshold = cfg2[conv_cfg_pkg::C2_DISCH_THR];
    assign cfg_o.input_protect_enable = cfg3[conv_cfg_pkg::C3_IVP];
    assign cfg_o.input_regulation_select = cfg3[conv_cfg_pkg::C3_IVR];
    assign cfg_o.voltage_detect_enable = cfg3[conv_cfg_pkg::C3_DET_EN];
    assign cfg_o.voltage_detect_falling_level =
        cfg3[conv_cfg_pkg::C3_DET_LSB +: 5];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_unimpl_zero: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg0[7] && !cfg2[7])
        else $error("unimplemented bit reads one");

    chk_reset_cfg0: assert property (
        @(posedge clk_sys_i) !rst_n_i |=> cfg0 == 8'h32)
        else $error("config0 reset value wrong");

    chk_reset_all: assert property (
        @(posedge clk_sys_i) !rst_n_i |=>
        cfg1 == 8'h09 && cfg2 == 8'h40 && cfg3 == 8'h20)
        else $error("config1..3 reset value wrong");

    chk_write_cfg0: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.power_stage_enable == $past(wdata_i[0])
        && cfg_o.negative_limit_enable == $past(wdata_i[6]))
        else $error("config0 write not taken");

    chk_hold_cfg1: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr1 |=> $stable(cfg1))
        else $error("config1 changed without write");

    chk_disch_fold: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg2[3:2] == 2'h3 |-> cfg_o.discharge_current_select == 2'h2)
        else $error("discharge code three not fast");

    chk_read_data: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_i && addr_i == 8'hd2 && !wr_i |=>
        rvalid_o && rdata_o == cfg2 && !rdata_o[7])
        else $error("config2 readback wrong");

    chk_read_unmapped: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_i && addr_i > 8'hd3 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    chk_detect_level: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr3 |=> cfg_o.voltage_detect_falling_level == $past(wdata_i[4:0])
        && cfg_o.input_protect_enable == $past(wdata_i[7]))
        else $error("config3 write not taken");

    chk_aux_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.aux_regulator_enable == $past(wdata_i[5]))
        else $error("aux regulator write not taken");

    chk_monitor_limiter: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.imon_limiter_enable == $past(wdata_i[4]))
        else $error("monitor limiter write not taken");

    chk_hiccup_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.hiccup_enable == $past(wdata_i[3]))
        else $error("hiccup write not taken");

    chk_spread_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.dual_spread_enable == $past(wdata_i[2]))
        else $error("spread spectrum write not taken");

    chk_sleep_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr0 |=> cfg_o.micro_sleep_enable == $past(wdata_i[1]))
        else $error("micro sleep write not taken");

    chk_stage_reset: assert property (
        @(posedge clk_sys_i) !rst_n_i |=> !cfg_o.power_stage_enable)
        else $error("power stage on after reset");

    chk_thermal_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.thermal_warning_enable == $past(wdata_i[7]))
        else $error("thermal enable write not taken");

    chk_thermal_level: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.thermal_warning_level == $past(wdata_i[6:5]))
        else $error("thermal level write not taken");

    chk_fault_mode: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.fault_pin_interrupt_mode == $past(wdata_i[4]))
        else $error("fault pin mode write not taken");

    chk_track_start: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.tracking_direct_startup == $past(wdata_i[3]))
        else $error("tracking start write not taken");

    chk_bias_priority: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.bias_supply_priority == $past(wdata_i[2]))
        else $error("bias priority write not taken");

    chk_two_phase: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr1 |=> cfg_o.two_phase_forced_pwm_enable == $past(wdata_i[1])
        && cfg_o.two_phase_power_save_enable == $past(wdata_i[0]))
        else $error("two-phase write not taken");

    chk_down_ramp: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr2 |=> cfg_o.active_down_ramp_enable == $past(wdata_i[6]))
        else $error("down ramp write not taken");

    chk_slew_select: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr2 |=> cfg_o.ramp_slew_select == $past(wdata_i[5:4]))
        else $error("slew write not taken");

    chk_disch_pass: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg2[3:2] != 2'h3 |-> cfg_o.discharge_current_select == cfg2[3:2])
        else $error("discharge code not passed through");

    chk_disch_stage: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr2 |=> cfg_o.discharge_with_stage_enable == $past(wdata_i[1]))
        else $error("discharge with stage write not taken");

    chk_disch_thresh: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr2 |=> cfg_o.discharge_to_threshold == $past(wdata_i[0]))
        else $error("discharge to threshold write not taken");

    chk_input_regulation: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr3 |=> cfg_o.input_regulation_select == $past(wdata_i[6]))
        else $error("input regulation write not taken");

    chk_detect_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr3 |=> cfg_o.voltage_detect_enable == $past(wdata_i[5]))
        else $error("detect enable write not taken");

    chk_hold_cfg0: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr0 |=> $stable(cfg0))
        else $error("config0 changed without write");

    chk_hold_cfg2: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr2 |=> $stable(cfg2))
        else $error("config2 changed without write");

    chk_hold_cfg3: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr3 |=> $stable(cfg3))
        else $error("config3 changed without write");

endmodule // converter_config_regs
